//--- test_uc_mixer_chain.sv
// Purpose: self-checking bench of the upconversion mixer chain
// Assumes: register strobes are one-cycle pulses, reads answer a cycle later
// Notes:   all sample inputs come from the source model, none are tied
`timescale 1ns/1ps
module test_uc_mixer_chain;
  logic           clk = 1'b0;
  logic           rst_n = 1'b0;
  logic           reg_wr = 1'b0;
  logic           reg_rd = 1'b0;
  logic           phstr = 1'b0;
  logic           go = 1'b0;
  logic [4:0]     reg_addr = '0;
  logic [7:0]     reg_wdata = '0;
  logic [7:0]     reg_rdata, r1, r2;
  uc_pkg::uc_iq_s smp = '0;
  uc_pkg::uc_iq_s iq, hp_out, fm_out, cm_out, p;
  logic           vld, hp_out_vld, nco_tick;
  int             err_total = 0;
  int             samples_checked = 0;
  logic [7:0]     mtab [3] = '{8'h81, 8'h80, 8'h81};
  logic [7:0]     ttab [3] = '{8'h01, 8'h01, 8'hff};
  logic [7:0]     dtab [3] = '{8'h04, 8'h02, 8'hfc};
  logic [7:0]     htab [4] = '{8'h8c, 8'h8d, 8'h8e, 8'h8f};

  // clock of 25 ns period
  always #12.5 clk = ~clk;

  uc_src i_src (.clk(clk), .rst_n(rst_n), .go(go), .smp(smp), .iq(iq), .vld(vld));

  uc_mixer_chain i_dut (
    .clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .phstr(phstr), .hp_in(iq), .hp_in_vld(vld), .hp_out(hp_out),
    .hp_out_vld(hp_out_vld), .fm_in(iq), .nco_tick(nco_tick),
    .fm_out(fm_out), .cm_in(iq), .cm_out(cm_out)
  );

  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one register write, strobe held for exactly one edge
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // one register read, data taken once the registered answer settles
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // phase strobe sampled at the edge on which this task returns
  task automatic strobe;
    @(posedge clk);
    phstr <= 1'b1;
    @(posedge clk);
    phstr <= 1'b0;
  endtask

  // coarse mixer element k for select code c
  function automatic uc_pkg::uc_iq_s cexp(input logic [3:0] c, input logic [1:0] k,
                                          input uc_pkg::uc_iq_s s);
    logic signed [15:0] a, b, t;
    a = s.a;
    b = s.b;
    if (c[3:2] == 2'b01) begin
      a = (c[1] ^ k[0]) ? s.a : -s.a;
      b = (c[0] ^ k[0]) ? s.b : -s.b;
    end else if (c[3]) begin
      for (int i = 0; i < k; i++) begin
        t = a;
        a = c[2] ? b : -b;
        b = c[2] ? -t : t;
      end
      if (c[1]) a = -a;
      if (c[0]) b = -b;
    end
    return uc_pkg::uc_iq_s'({a, b});
  endfunction

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // watchdog against a hang
  initial begin
    #(25 * 4000);
    err_total++;
    print_verdict;
  end

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    smp   <= '{a: 16'sh0100, b: 16'sh0300};
    go    <= 1'b1;
    // oscillator registers: reset value, read back, unmapped place
    for (int i = 9; i <= 14; i++) begin
      rd(5'(i), r1);
      check(32'(r1), 32'h0);
      wr(5'(i), 8'(8'ha0 + i));
      rd(5'(i), r1);
      check(32'(r1), 32'(8'ha0 + i));
    end
    wr(5'h1f, 8'h5a);
    rd(5'h1f, r1);
    check(32'(r1), 32'h0);
    // fixed filter centres and zero even-offset taps
    check(32'(uc_pkg::FIR13_COEF[25]), 32'h0000_8000);
    check(32'(uc_pkg::SECOND_HALFBAND_FILTER_COEF[9]), 32'h0000_1000);
    check(32'(uc_pkg::INVSINC_COEF[4]), 32'h0000_0250);
    for (int i = 1; i < 25; i += 2) begin
      check(32'(uc_pkg::FIR13_COEF[i]), 32'h0);
    end
    $display("test registers done");
    // accumulator: clear by strobe, step per tick, negative words
    wr(uc_pkg::ADDR_TW0, 8'h00);
    wr(uc_pkg::ADDR_TW1, 8'h00);
    wr(uc_pkg::ADDR_TW2, 8'h00);
    for (int i = 0; i < 3; i++) begin
      wr(uc_pkg::ADDR_TW3, ttab[i]);
      wr(uc_pkg::ADDR_MODE_CFG, mtab[i]);
      if (i == 0) begin
        strobe;
        rd(uc_pkg::ADDR_STAT_ACC, r1);
        check(32'(r1), 32'h01);
      end
      rd(uc_pkg::ADDR_STAT_ACC, r1);
      repeat (2) @(posedge clk);
      rd(uc_pkg::ADDR_STAT_ACC, r2);
      check(32'(8'(r2 - r1)), 32'(dtab[i]));
    end
    $display("test accumulator done");
    // fine mixer gain and phase offset with a still oscillator
    wr(uc_pkg::ADDR_TW3, 8'h00);
    wr(uc_pkg::ADDR_PO0, 8'h00);
    wr(uc_pkg::ADDR_PO1, 8'h00);
    wr(uc_pkg::ADDR_MODE_CFG, 8'h81);
    smp <= '{a: 16'sh4000, b: 16'sh0000};
    for (int g = 0; g < 3; g++) begin
      wr(uc_pkg::ADDR_CFG2, (g == 0) ? 8'h00 : 8'h40); // gain 0 halves the mixer output
      if (g == 2) wr(uc_pkg::ADDR_PO1, 8'h40);
      strobe;
      repeat (3) @(posedge clk);
      #1;
      check(fm_out, (g == 0) ? 32'h1fff_0000 : (g == 1) ? 32'h3fff_0000 : 32'h0000_3fff);
    end
    $display("test fine mixer done");
    // high-pass inversion per interpolation mode
    smp <= '{a: 16'sh0100, b: 16'sh0300};
    wr(uc_pkg::ADDR_CFG2, 8'h00);
    for (int m = 0; m < 4; m++) begin
      wr(uc_pkg::ADDR_MODE_CFG, htab[m]);
      repeat (3) @(posedge clk);
      for (int n = 0; n < 4; n++) begin
        @(posedge clk);
        #1;
        check(32'(hp_out_vld), 32'h1);
        if (n > 0) check(hp_out, htab[m][1] ? {-p.a, -p.b} : p);
        p = hp_out;
      end
      check((hp_out.a == 16'sh0100 || hp_out.a == -16'sh0100) ? 32'h1 : 32'h0, 32'h1);
    end
    $display("test high-pass done");
    // coarse mixer: every select code, start index taken from the code
    for (int c = 0; c < 16; c++) begin
      wr(uc_pkg::ADDR_MODE_CFG, {2'b10, 2'(c), 4'h1});
      wr(uc_pkg::ADDR_CFG2, 8'(c));
      strobe;
      for (int k = 0; k < 4; k++) begin
        @(posedge clk);
        #1;
        check(cm_out, cexp(4'(c), 2'(c + k), smp));
      end
    end
    $display("test coarse mixer done");
    print_verdict;
  end
endmodule

//--- uc_mixer_chain.sv
// Purpose: high-pass inversion, fine mixer with oscillator, coarse mixer
// Assumes: clk is the converter sample clock; all inputs synchronous to it
// Notes:   the half-rate clock is an enable toggling every clk cycle
`timescale 1ns/1ps
module uc_mixer_chain (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  input  wire logic [4:0]    reg_addr,
  input  wire logic [7:0]    reg_wdata,
  output logic      [7:0]    reg_rdata,
  input  wire logic          phstr,
  input  wire uc_pkg::uc_iq_s hp_in,
  input  wire logic          hp_in_vld,
  output uc_pkg::uc_iq_s     hp_out,
  output logic               hp_out_vld,
  input  wire uc_pkg::uc_iq_s fm_in,
  output logic               nco_tick,
  output uc_pkg::uc_iq_s     fm_out,
  input  wire uc_pkg::uc_iq_s cm_in,
  output uc_pkg::uc_iq_s     cm_out
);

  typedef struct packed {
    logic [31:0]    tw;     // tuning word
    logic [15:0]    po;     // phase offset
    logic [7:0]     cfg2;   // second_config_register
    logic [7:0]     mcfg;   // mode configuration
    logic [31:0]    acc;    // oscillator phase accumulator
    logic           half;   // half-rate enable phase
    logic           hp_sgn; // next high-pass sign, 1 means negate
    logic [1:0]     cm_k;   // coarse sequence index
    uc_pkg::uc_iq_s hp_o;
    logic           hp_v;
    uc_pkg::uc_iq_s fm_o;
    uc_pkg::uc_iq_s cm_o;
    logic [7:0]     rd;
  } uc_state_s;

  uc_state_s          st_r;
  uc_state_s          st_nxt;
  uc_pkg::uc_mode_e   mode;
  logic               phstr_evt;
  logic               hp_on_a;
  logic               hp_on_b;
  logic               gain;
  logic [3:0]         cm_sel;
  logic [15:0]        nco_phase;
  logic signed [15:0] sin_v;
  logic signed [15:0] cos_v;
  logic signed [31:0] p_ac;
  logic signed [31:0] p_bs;
  logic signed [31:0] p_as;
  logic signed [31:0] p_bc;
  logic signed [32:0] sum_i;
  logic signed [32:0] sum_q;
  logic signed [32:0] scl_i;
  logic signed [32:0] scl_q;
  logic               sw_k;
  logic               neg_a;
  logic               neg_b;
  logic [7:0]         rd_mux;

  // negate with saturation of the most negative code
  function automatic logic signed [15:0] lane(input logic signed [15:0] x, input logic n);
    if (!n) begin
      lane = x;
    end else if (x == 16'sh8000) begin
      lane = 16'sh7fff;
    end else begin
      lane = -x;
    end
  endfunction

  // clip a wide product sum to 16 bits
  function automatic logic signed [15:0] sat16(input logic signed [32:0] v);
    if ((&v[32:15]) || !(|v[32:15])) begin
      sat16 = v[15:0];
    end else if (v[32]) begin
      sat16 = 16'sh8000;
    end else begin
      sat16 = 16'sh7fff;
    end
  endfunction

  // field decode
  always_comb begin
    mode    = uc_pkg::uc_mode_e'(st_r.mcfg[uc_pkg::MODE_LSB +: 2]);
    hp_on_a = st_r.mcfg[uc_pkg::HP_A_BIT] &&
              (mode == uc_pkg::UC_FOUR_X_LOW || mode == uc_pkg::UC_EIGHT_X);
    hp_on_b = st_r.mcfg[uc_pkg::HP_B_BIT] &&
              (mode == uc_pkg::UC_FOUR_X_LOW || mode == uc_pkg::UC_EIGHT_X);
    gain    = st_r.cfg2[uc_pkg::GAIN_BIT];
    cm_sel  = st_r.cfg2[uc_pkg::CM_LSB +: 4];
  end

  // strobe latched on every sample or only on the divided clock edge
  assign phstr_evt = phstr && (st_r.mcfg[uc_pkg::PH_CLK_BIT] || st_r.half);

  // oscillator clock: full rate in 4x, half rate elsewhere
  assign nco_tick = (mode == uc_pkg::UC_FOUR_X) || st_r.half;

  // phase seen by the table is accumulator plus offset
  assign nco_phase = st_r.acc[31:16] + st_r.po;

  uc_sincos u_sincos (
    .phase   (nco_phase),
    .sin_val (sin_v),
    .cos_val (cos_v)
  );

  // complex products of channel A as I and channel B as Q
  always_comb begin
    p_ac  = fm_in.a * cos_v;
    p_bs  = fm_in.b * sin_v;
    p_as  = fm_in.a * sin_v;
    p_bc  = fm_in.b * cos_v;
    sum_i = {p_ac[31], p_ac} - {p_bs[31], p_bs};
    sum_q = {p_as[31], p_as} + {p_bc[31], p_bc};
    scl_i = gain ? (sum_i >>> 15) : (sum_i >>> 16);
    scl_q = gain ? (sum_q >>> 15) : (sum_q >>> 16);
  end

  // coarse sequence swap and sign for the current index
  always_comb begin
    sw_k  = 1'b0;
    neg_a = 1'b0;
    neg_b = 1'b0;
    case (cm_sel[3:2])
      2'b01: begin
        neg_a = ~cm_sel[1] ^ st_r.cm_k[0];
        neg_b = ~cm_sel[0] ^ st_r.cm_k[0];
      end
      2'b10: begin
        sw_k  = st_r.cm_k[0];
        neg_a = (st_r.cm_k == 2'h1 || st_r.cm_k == 2'h2) ^ cm_sel[1];
        neg_b = st_r.cm_k[1] ^ cm_sel[0];
      end
      2'b11: begin
        sw_k  = st_r.cm_k[0];
        neg_a = st_r.cm_k[1] ^ cm_sel[1];
        neg_b = (st_r.cm_k == 2'h1 || st_r.cm_k == 2'h2) ^ cm_sel[0];
      end
      default: begin
        sw_k  = 1'b0; // 00XX passes samples through
      end
    endcase
  end

  // read data selection, unmapped addresses read zero
  always_comb begin
    case (reg_addr)
      uc_pkg::ADDR_MODE_CFG: rd_mux = st_r.mcfg;
      uc_pkg::ADDR_CFG2:     rd_mux = st_r.cfg2;
      uc_pkg::ADDR_TW0:      rd_mux = st_r.tw[7:0];
      uc_pkg::ADDR_TW1:      rd_mux = st_r.tw[15:8];
      uc_pkg::ADDR_TW2:      rd_mux = st_r.tw[23:16];
      uc_pkg::ADDR_TW3:      rd_mux = st_r.tw[31:24];
      uc_pkg::ADDR_PO0:      rd_mux = st_r.po[7:0];
      uc_pkg::ADDR_PO1:      rd_mux = st_r.po[15:8];
      uc_pkg::ADDR_STAT_ACC: rd_mux = st_r.acc[31:24];
      uc_pkg::ADDR_STAT_CM:  rd_mux = {6'h00, st_r.cm_k};
      default:               rd_mux = 8'h00;
    endcase
  end

  // next state of the whole block
  always_comb begin
    st_nxt = st_r;
    // register writes
    if (reg_wr) begin
      case (reg_addr)
        uc_pkg::ADDR_MODE_CFG: st_nxt.mcfg = reg_wdata;
        uc_pkg::ADDR_CFG2:     st_nxt.cfg2 = reg_wdata;
        uc_pkg::ADDR_TW0:      st_nxt.tw[7:0] = reg_wdata;
        uc_pkg::ADDR_TW1:      st_nxt.tw[15:8] = reg_wdata;
        uc_pkg::ADDR_TW2:      st_nxt.tw[23:16] = reg_wdata;
        uc_pkg::ADDR_TW3:      st_nxt.tw[31:24] = reg_wdata;
        uc_pkg::ADDR_PO0:      st_nxt.po[7:0] = reg_wdata;
        uc_pkg::ADDR_PO1:      st_nxt.po[15:8] = reg_wdata;
        default:               st_nxt.rd = st_r.rd; // read-only or unmapped
      endcase
    end
    if (reg_rd) begin
      st_nxt.rd = rd_mux;
    end
    // half-rate divider restarts on the strobe
    st_nxt.half = phstr_evt ? 1'b0 : ~st_r.half;
    // accumulator wraps modulo 2^32 so upper-half words run backwards
    if (phstr_evt) begin
      st_nxt.acc = 32'h0000_0000;
    end else if (nco_tick) begin
      st_nxt.acc = st_r.acc + st_r.tw;
    end
    // high-pass inversion on first filter samples
    st_nxt.hp_v = hp_in_vld;
    if (phstr_evt) begin
      st_nxt.hp_sgn = 1'b0;
    end else if (hp_in_vld) begin
      st_nxt.hp_sgn = ~st_r.hp_sgn;
    end
    if (hp_in_vld) begin
      st_nxt.hp_o.a = lane(hp_in.a, hp_on_a && st_r.hp_sgn);
      st_nxt.hp_o.b = lane(hp_in.b, hp_on_b && st_r.hp_sgn);
    end
    // fine mixer output updates at the oscillator rate
    if (nco_tick) begin
      st_nxt.fm_o.a = sat16(scl_i);
      st_nxt.fm_o.b = sat16(scl_q);
    end
    // coarse mixer works on every converter sample
    st_nxt.cm_o.a = lane(sw_k ? cm_in.b : cm_in.a, neg_a);
    st_nxt.cm_o.b = lane(sw_k ? cm_in.a : cm_in.b, neg_b);
    if (phstr_evt) begin
      st_nxt.cm_k = st_r.mcfg[uc_pkg::PH_DEL_LSB +: 2];
    end else begin
      st_nxt.cm_k = st_r.cm_k + 2'h1;
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r        <= '0;
      st_r.tw     <= uc_pkg::RST_TW;
      st_r.po     <= uc_pkg::RST_PO;
      st_r.cfg2   <= uc_pkg::RST_BYTE;
      st_r.mcfg   <= uc_pkg::RST_BYTE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  assign reg_rdata  = st_r.rd;
  assign hp_out     = st_r.hp_o;
  assign hp_out_vld = st_r.hp_v;
  assign fm_out     = st_r.fm_o;
  assign cm_out     = st_r.cm_o;

  // checks on the running block
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  acc_clear_a: assert property (phstr_evt |=> st_r.acc == 32'h0000_0000)
    else $error("accumulator not cleared by phase strobe");

  acc_step_a: assert property (nco_tick && !phstr_evt && !reg_wr
                               |=> st_r.acc == $past(st_r.acc) + st_r.tw)
    else $error("accumulator did not advance by tuning word");

  full_rate_a: assert property (mode == uc_pkg::UC_FOUR_X |-> nco_tick)
    else $error("oscillator missed a tick in four-x mode");

  half_rate_a: assert property (mode != uc_pkg::UC_FOUR_X && nco_tick && !reg_wr
                                |=> !nco_tick)
    else $error("oscillator ticked twice in a row at half rate");

  cm_step_a: assert property (!phstr_evt |=> st_r.cm_k == $past(st_r.cm_k) + 2'h1)
    else $error("coarse index did not advance");

  cm_restart_a: assert property (phstr_evt
                                 |=> st_r.cm_k == $past(st_r.mcfg[5:4]))
    else $error("coarse index not restarted at programmed value");

  cm_bypass_a: assert property (cm_sel[3:2] == 2'b00 |=> cm_out == $past(cm_in))
    else $error("coarse mixer altered samples while disabled");

  hp_off_a: assert property (hp_in_vld && !hp_on_a && !hp_on_b
                             |=> hp_out == $past(hp_in) && hp_out_vld)
    else $error("high-pass inversion applied outside its modes");

  tw_write_a: assert property (reg_wr && reg_addr == uc_pkg::ADDR_TW0
                               |=> st_r.tw[7:0] == $past(reg_wdata))
    else $error("tuning word low byte not written");

  // checks on the sample paths, the full-rate strobe and the top tuning word and phase offset bytes
  hp_inv_a: assert property (hp_in_vld && hp_on_a && st_r.hp_sgn && hp_in.a != 16'sh8000
                             |=> hp_out.a == 16'(-$past(hp_in.a)))
    else $error("high-pass lane A not inverted");

  hp_pass_a: assert property (hp_in_vld && !st_r.hp_sgn |=> hp_out == $past(hp_in))
    else $error("high-pass sample altered on a positive step");

  hp_sign_a: assert property (hp_in_vld && !phstr_evt
                              |=> st_r.hp_sgn != $past(st_r.hp_sgn))
    else $error("high-pass sign did not alternate");

  hp_hold_a: assert property (!hp_in_vld |=> hp_out == $past(hp_out) && !hp_out_vld)
    else $error("high-pass output moved without a sample");

  fm_hold_a: assert property (!nco_tick |=> fm_out == $past(fm_out))
    else $error("fine mixer output moved without a tick");

  tw_top_a: assert property (reg_wr && reg_addr == uc_pkg::ADDR_TW3
                             |=> st_r.tw[31:24] == $past(reg_wdata))
    else $error("tuning word top byte not written");

  po_write_a: assert property (reg_wr && reg_addr == uc_pkg::ADDR_PO1
                               |=> st_r.po[15:8] == $past(reg_wdata))
    else $error("phase offset high byte not written");

  strobe_full_a: assert property (phstr && st_r.mcfg[uc_pkg::PH_CLK_BIT]
                                  |=> !st_r.half && st_r.acc == 32'h0000_0000)
    else $error("full-rate strobe did not restart the oscillator");

  cm_half_a: assert property (cm_sel[3:2] == 2'b01 && !cm_sel[1] && !st_r.cm_k[0]
                              && cm_in.a != 16'sh8000 |=> cm_out.a == 16'(-$past(cm_in.a)))
    else $error("half-rate mixer did not start A negated");

  cm_quarter_a: assert property (cm_sel == 4'b1000 && st_r.cm_k == 2'h1
                                 && cm_in.b != 16'sh8000
                                 |=> cm_out.a == 16'(-$past(cm_in.b))
                                     && cm_out.b == $past(cm_in.a))
    else $error("plus quarter-rate second element wrong");

  cm_minus_a: assert property (cm_sel == 4'b1100 && st_r.cm_k == 2'h1
                               && cm_in.a != 16'sh8000
                               |=> cm_out.a == $past(cm_in.b)
                                   && cm_out.b == 16'(-$past(cm_in.a)))
    else $error("minus quarter-rate second element wrong");

endmodule

//--- uc_pkg.sv
// Purpose: shared constants and carrier types of the upconversion mixer chain
// Assumes: 8-bit register port with 5-bit addresses, 16-bit signed samples
// Notes:   filter coefficient sets are kept here for the interpolation filters
package uc_pkg;

  // register addresses
  localparam logic [4:0] ADDR_MODE_CFG = 5'h01; // interpolation mode, high-pass, strobe setup
  localparam logic [4:0] ADDR_CFG2     = 5'h02; // second_config_register
  localparam logic [4:0] ADDR_TW0      = 5'h09; // nco_tuning_word_0, bits 7:0
  localparam logic [4:0] ADDR_TW1      = 5'h0a; // nco_tuning_word_1, bits 15:8
  localparam logic [4:0] ADDR_TW2      = 5'h0b; // nco_tuning_word_2, bits 23:16
  localparam logic [4:0] ADDR_TW3      = 5'h0c; // nco_tuning_word_3, bits 31:24
  localparam logic [4:0] ADDR_PO0      = 5'h0d; // nco_phase_offset_0, bits 7:0
  localparam logic [4:0] ADDR_PO1      = 5'h0e; // nco_phase_offset_1, bits 15:8
  localparam logic [4:0] ADDR_STAT_ACC = 5'h10; // accumulator top byte, read only
  localparam logic [4:0] ADDR_STAT_CM  = 5'h11; // coarse sequence index, read only

  // field positions
  localparam int MODE_LSB      = 0; // two bits, see uc_mode_e
  localparam int HP_A_BIT      = 2;
  localparam int HP_B_BIT      = 3;
  localparam int PH_DEL_LSB    = 4; // two bits, initial coarse sequence index
  localparam int PH_CLK_BIT    = 7; // phase strobe latch clock select
  localparam int GAIN_BIT      = 6; // mixer_gain_select in second_config_register
  localparam int CM_LSB        = 0; // four bits, coarse_sequence_select

  // reset values
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [31:0] RST_TW   = 32'h0000_0000;
  localparam logic [15:0] RST_PO   = 16'h0000;

  // rate limits of the oscillator and converter in MHz
  localparam int NCO_MAX_CLK_MHZ = 320;
  localparam int DAC_MAX_MHZ     = 500;

  // symmetric filter halves, outer tap first, centre tap last
  localparam int FIR13_COEF [26] = '{8, 0, -24, 0, 58, 0, -120, 0, 221, 0, -380, 0, 619, 0,
                                     -971, 0, 1490, 0, -2288, 0, 3649, 0, -6628, 0, 20750,
                                     32768};
  localparam int SECOND_HALFBAND_FILTER_COEF [10]  = '{9, 0, -58, 0, 214, 0, -638, 0, 2521, 4096};
  localparam int INVSINC_COEF [5] = '{1, -4, 13, -50, 592};

  typedef enum logic [1:0] {
    UC_TWO_X      = 2'b00,
    UC_FOUR_X     = 2'b01,
    UC_FOUR_X_LOW = 2'b10,
    UC_EIGHT_X    = 2'b11
  } uc_mode_e;

  typedef struct packed {
    logic signed [15:0] a;
    logic signed [15:0] b;
  } uc_iq_s;

endpackage

//--- uc_sincos.sv
// Purpose: sine and cosine of a 16-bit phase for the fine_mixer oscillator
// Assumes: 64 points per turn, quarter-wave table scaled to 32767
// Notes:   purely combinational, the caller registers the mixed result
`timescale 1ns/1ps
module uc_sincos (
  input  wire logic        [15:0] phase,
  output logic signed [15:0] sin_val,
  output logic signed [15:0] cos_val
);

  localparam logic [15:0] QTAB [17] = '{16'h0000, 16'h0c8c, 16'h18f9, 16'h2528, 16'h30fb,
                                         16'h3c56, 16'h471c, 16'h5133, 16'h5a82, 16'h62f1,
                                         16'h6a6d, 16'h70e2, 16'h7641, 16'h7a7c, 16'h7d89,
                                         16'h7f61, 16'h7fff};

  // fold the 6-bit index onto the quarter wave and restore the sign
  function automatic logic signed [15:0] qsin(input logic [5:0] idx);
    logic [4:0]  j;
    logic [15:0] m;
    j = {1'b0, idx[3:0]};
    if (idx[4]) begin
      j = 5'h10 - j;
    end
    m = QTAB[j];
    qsin = idx[5] ? -$signed(m) : $signed(m);
  endfunction

  // cosine leads sine by a quarter turn
  always_comb begin
    sin_val = qsin(phase[15:10]);
    cos_val = qsin(phase[15:10] + 6'h10);
  end

endmodule

//--- uc_src.sv
// Purpose: baseband sample source feeding the mixer chain
// Assumes: one complex sample per clk while go is high
// Notes:   idle data is inverted every cycle so a stale value never passes
`timescale 1ns/1ps
module uc_src (
  input  wire logic           clk,
  input  wire logic           rst_n,
  input  wire logic           go,
  input  wire uc_pkg::uc_iq_s smp,
  output uc_pkg::uc_iq_s      iq,
  output logic                vld
);
  // present a sample per go cycle, scramble the bus when idle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      iq  <= '0;
      vld <= 1'b0;
    end else begin
      vld <= go;
      iq  <= go ? smp : ~iq;
    end
  end
endmodule
